// File: pkg/smsp_pkg.sv
// Shared constants and types of the serial peripheral port.
// Assumes an 8-bit special-function-register access port on one synchronous clock.
package smsp_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h9a;
  localparam logic [7:0] ADDR_DAT = 8'h9b;
  localparam logic [7:0] ADDR_CKR = 8'h9d;
  localparam logic [7:0] ADDR_CTL = 8'hf8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RST  = 8'h07;
  localparam logic [7:0] CTL_RST  = 8'h00;
  localparam logic [7:0] CKR_RST  = 8'h00;
  localparam logic [7:0] DAT_RST  = 8'h00;
  localparam logic [2:0] BC_RST   = 3'h0;
  localparam logic [8:0] GAP_RST  = 9'h000;
  localparam logic [3:0] SYNC_RST = 4'hf;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_PHA  = 7;
  localparam int CFG_POL  = 6;
  localparam int CFG_FRSH = 2;
  localparam int CTL_TRANSFER_COMPLETE_FLAG = 7;
  localparam int CTL_WRITE_COLLISION_FLAG = 6;
  localparam int CTL_MODE_FAULT_FLAG = 5;
  localparam int CTL_OVR  = 4;
  localparam int CTL_MST  = 1;
  localparam int CTL_EN   = 0;
  localparam int MSB      = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smsp_sfr_req_t;

  typedef enum logic [0:0] {
    MST_IDLE,
    MST_SHIFT
  } smsp_mst_state_t;

endpackage : smsp_pkg

// File: core/smsp_sync.sv
// Two-flop synchroniser bank for the serial pins.
// Assumes inputs asynchronous to core_clk_i; only the second stage is read.
`timescale 1ns/1ns
module smsp_sync #(
  parameter int          W       = 4,
  parameter logic [3:0]  RST_VAL = 4'hf
) (
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // One two-stage chain per bit
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          meta_r[g] <= RST_VAL[g];
          sync_o[g] <= RST_VAL[g];
        end else begin
          meta_r[g] <= async_i[g];
          sync_o[g] <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule : smsp_sync

// File: core/smsp_clkdiv.sv
// Half-period tick generator for the master serial clock.
// Assumes run_i stays high for the whole transfer; rate_i is held steady meanwhile.
`timescale 1ns/1ns
module smsp_clkdiv (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       run_i,
  input  wire logic [7:0] rate_i,
  output logic            tick_o
);

  logic [7:0] cnt_r;

  // ----------------------------------------------------------------
  // One tick every rate_i+1 cycles, so SCK = clk / (2*(rate_i+1))
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !run_i) begin
      cnt_r  <= smsp_pkg::CKR_RST;
      tick_o <= 1'b0;
    end else if (cnt_r == rate_i) begin
      cnt_r  <= smsp_pkg::CKR_RST;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 8'h01;
      tick_o <= 1'b0;
    end
  end

endmodule : smsp_clkdiv

// File: core/smsp_port.sv
// Serial peripheral port: master or selected slave, with its four registers.
// Assumes a single 25 MHz core clock and a synchronous register access port.
`timescale 1ns/1ns
// Behaviour
// (R01) Master serial bit rate never exceeds half the core clock.
// (R02) External master keeps slave bit rate at or below a tenth of the clock.
// (R03) Both data lines shift most significant bit first.
// (R04) Unselected slave releases its slave-out line.
// (R05) External master holds select low for the whole transfer.
// (R06) Data write in master mode starts a transfer at once.
// (R07) Transfer end sets the complete flag and raises the interrupt.
// (R08) Master frame length is one to eight bits from the frame-size field.
// (R09) Received bits replace the data; complete flag means receive data ready.
// (R10) Data write during a transfer sets write-collision and is dropped.
// (R11) Unread buffer at frame end sets overrun, keeps old data.
// (R12) Slave sets complete flag when select returns high.
// (R13) Slave sends new data only if written before the frame starts.
// (R14) Select low in master mode sets mode-fault and clears master and enable.
// (R15) Software checks slave-selected status before taking the bus.
// (R16) Clock-phase bit picks sampling on first or second edge.
// (R17) Clock-polarity bit sets the idle level of the serial clock.
// (R18) Both ends use the same phase and polarity; disable before changing.
// (R19) Clock-rate register acts in master mode only.
// (R20) Read-only bit-count field reports the bit last transmitted.
// (R21) Complete, mode-fault and overrun flags stay set until software clears.
// (R22) Frame-size code n gives n plus one bits.
// (R23) Master clock is half the core clock over rate plus one.
// (R24) Slave pins pass a two-flop synchroniser before use.
module smsp_port (
  input  wire logic                    core_clk_i,
  input  wire logic                    srst_i,
  input  wire smsp_pkg::smsp_sfr_req_t sfr_req_i,
  output logic [7:0]                   sfr_rdata_o,
  output logic                         irq_o,
  input  wire logic                    nss_n_i,
  input  wire logic                    sck_i,
  output logic                         sck_o,
  output logic                         sck_oe_n_o,
  input  wire logic                    mosi_i,
  output logic                         mosi_o,
  output logic                         mosi_oe_n_o,
  input  wire logic                    miso_i,
  output logic                         miso_o,
  output logic                         miso_oe_n_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  smsp_pkg::smsp_mst_state_t st_r;
  logic [3:0] pin_s;
  logic       nss_s, sck_s, mosi_s, miso_s;
  logic       pha_r, pol_r;
  logic [2:0] frs_r, bc_r;
  logic [7:0] ckr_r, shift_r, rx_buf_r, shift_nxt, push_val;
  logic       transfer_complete_flag_r, write_collision_flag_r, mode_fault_flag_r, ovr_r, master_select_bit_r, en_r;
  logic       slv_act_r, samp_r, out_r, sck_r, sck_prev_r, rx_full_r;
  logic       tick, slv_sel, sck_edge, lead_ev, trail_ev, din;
  logic       mst_busy, busy, mst_done, slv_end, push, ovr_ev;
  logic       wr_cfg, wr_ctl, wr_ckr, wr_dat, rd_dat;
  logic       start, load, write_collision_flag_ev, mode_fault_flag_cond;

  // Address match, shared by read and write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    hit = (a == t);
  endfunction : hit

  // ----------------------------------------------------------------
  // Pin synchronisers and master clock divider
  // ----------------------------------------------------------------
  smsp_sync #(.W(4), .RST_VAL(smsp_pkg::SYNC_RST)) u_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    ({nss_n_i, sck_i, mosi_i, miso_i}),
    .sync_o     (pin_s)
  ); // [R24]

  // Divider runs only during a master transfer, so the rate is inert as slave
  smsp_clkdiv u_div (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .run_i      (mst_busy),
    .rate_i     (ckr_r),
    .tick_o     (tick)
  ); // [R19] [R23] [R01]

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign {nss_s, sck_s, mosi_s, miso_s} = pin_s;
  assign wr_cfg    = sfr_req_i.wr && hit(sfr_req_i.addr, smsp_pkg::ADDR_CFG);
  assign wr_ctl    = sfr_req_i.wr && hit(sfr_req_i.addr, smsp_pkg::ADDR_CTL);
  assign wr_ckr    = sfr_req_i.wr && hit(sfr_req_i.addr, smsp_pkg::ADDR_CKR);
  assign wr_dat    = sfr_req_i.wr && hit(sfr_req_i.addr, smsp_pkg::ADDR_DAT);
  assign rd_dat    = sfr_req_i.rd && hit(sfr_req_i.addr, smsp_pkg::ADDR_DAT);
  assign mst_busy  = (st_r == smsp_pkg::MST_SHIFT);
  assign slv_sel   = en_r && !master_select_bit_r && !nss_s;
  assign sck_edge  = slv_sel && (sck_s != sck_prev_r);
  assign mode_fault_flag_cond = master_select_bit_r && !nss_s;                              // [R14]
  assign busy      = mst_busy || slv_act_r;
  assign start     = wr_dat && !busy && en_r && master_select_bit_r && !mode_fault_flag_cond; // [R06]
  assign load      = wr_dat && !busy;                               // [R13]
  assign write_collision_flag_ev   = wr_dat && busy;                                // [R10]
  // Leading edge leaves the idle level, trailing edge returns to it
  assign lead_ev   = master_select_bit_r ? (mst_busy && tick && sck_r == pol_r)
                             : (sck_edge && sck_s != pol_r);        // [R16] [R17]
  assign trail_ev  = master_select_bit_r ? (mst_busy && tick && sck_r != pol_r)
                             : (sck_edge && sck_s == pol_r);
  assign din       = master_select_bit_r ? miso_s : mosi_s;
  assign shift_nxt = {shift_r[6:0], pha_r ? din : samp_r};          // [R03] [R16]
  assign mst_done  = master_select_bit_r && trail_ev && (bc_r == frs_r);        // [R08] [R22]
  assign slv_end   = slv_act_r && nss_s;                            // [R12]
  assign push      = mst_done || slv_end;
  assign push_val  = mst_done ? shift_nxt : shift_r;                // [R09]
  assign ovr_ev    = push && rx_full_r && !rd_dat;                  // [R11]

  // ----------------------------------------------------------------
  // Configuration and clock-rate registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pha_r <= smsp_pkg::CFG_RST[smsp_pkg::CFG_PHA];
      pol_r <= smsp_pkg::CFG_RST[smsp_pkg::CFG_POL];
      frs_r <= smsp_pkg::CFG_RST[smsp_pkg::CFG_FRSH:0];
    end else if (wr_cfg) begin
      pha_r <= sfr_req_i.wdata[smsp_pkg::CFG_PHA];
      pol_r <= sfr_req_i.wdata[smsp_pkg::CFG_POL];
      frs_r <= sfr_req_i.wdata[smsp_pkg::CFG_FRSH:0];                // [R08]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ckr_r <= smsp_pkg::CKR_RST;
    end else if (wr_ckr) begin
      ckr_r <= sfr_req_i.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Control bits; mode fault overrides a software write
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      master_select_bit_r <= smsp_pkg::CTL_RST[smsp_pkg::CTL_MST];
      en_r    <= smsp_pkg::CTL_RST[smsp_pkg::CTL_EN];
    end else if (mode_fault_flag_cond) begin
      master_select_bit_r <= 1'b0;                                              // [R14]
      en_r    <= 1'b0;
    end else if (wr_ctl) begin
      master_select_bit_r <= sfr_req_i.wdata[smsp_pkg::CTL_MST];
      en_r    <= sfr_req_i.wdata[smsp_pkg::CTL_EN];
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags: hardware set wins over a software clear
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      transfer_complete_flag_r <= smsp_pkg::CTL_RST[smsp_pkg::CTL_TRANSFER_COMPLETE_FLAG];
      write_collision_flag_r <= smsp_pkg::CTL_RST[smsp_pkg::CTL_WRITE_COLLISION_FLAG];
      mode_fault_flag_r <= smsp_pkg::CTL_RST[smsp_pkg::CTL_MODE_FAULT_FLAG];
      ovr_r  <= smsp_pkg::CTL_RST[smsp_pkg::CTL_OVR];
    end else begin
      transfer_complete_flag_r <= push || (wr_ctl ? sfr_req_i.wdata[smsp_pkg::CTL_TRANSFER_COMPLETE_FLAG] : transfer_complete_flag_r);   // [R07] [R21]
      write_collision_flag_r <= write_collision_flag_ev || (wr_ctl ? sfr_req_i.wdata[smsp_pkg::CTL_WRITE_COLLISION_FLAG] : write_collision_flag_r); // [R10]
      mode_fault_flag_r <= mode_fault_flag_cond || (wr_ctl ? sfr_req_i.wdata[smsp_pkg::CTL_MODE_FAULT_FLAG] : mode_fault_flag_r); // [R14] [R21]
      ovr_r  <= ovr_ev || (wr_ctl ? sfr_req_i.wdata[smsp_pkg::CTL_OVR] : ovr_r);    // [R11] [R21]
    end
  end

  // Any raised flag requests service; the CPU applies its own enable
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= transfer_complete_flag_r || write_collision_flag_r || mode_fault_flag_r || ovr_r;                  // [R07]
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer: double buffered on reads only
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_buf_r  <= smsp_pkg::DAT_RST;
      rx_full_r <= 1'b0;
    end else if (push && !ovr_ev) begin
      rx_buf_r  <= push_val;                                        // [R09]
      rx_full_r <= 1'b1;
    end else if (rd_dat) begin
      rx_full_r <= 1'b0;                                            // [R11]
    end
  end

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_r <= smsp_pkg::MST_IDLE;
    end else begin
      case (st_r)
        smsp_pkg::MST_IDLE: begin
          if (start) st_r <= smsp_pkg::MST_SHIFT;                   // [R06]
        end
        smsp_pkg::MST_SHIFT: begin
          if (mode_fault_flag_cond || mst_done) st_r <= smsp_pkg::MST_IDLE;
        end
        default: st_r <= smsp_pkg::MST_IDLE;
      endcase
    end
  end

  // Serial clock: parks at the polarity level, toggles on each tick
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sck_r <= smsp_pkg::CFG_RST[smsp_pkg::CFG_POL];
    end else if (!mst_busy) begin
      sck_r <= pol_r;                                               // [R17]
    end else if (tick) begin
      sck_r <= !sck_r;
    end
  end

  // Slave frame tracking; edges are counted only from the synced clock
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sck_prev_r <= 1'b1;
      slv_act_r  <= 1'b0;
    end else begin
      sck_prev_r <= sck_s;                                          // [R24]
      if (!slv_sel) slv_act_r <= 1'b0;
      else if (sck_edge) slv_act_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine, shared by both modes
  // ----------------------------------------------------------------
  // Writes are taken only between frames, so an in-flight frame is never disturbed
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      shift_r <= smsp_pkg::DAT_RST;
      samp_r  <= 1'b0;
      out_r   <= 1'b0;
      bc_r    <= smsp_pkg::BC_RST;
    end else if (load) begin
      shift_r <= sfr_req_i.wdata;                                   // [R06] [R13]
      out_r   <= sfr_req_i.wdata[smsp_pkg::MSB];                    // [R03]
      bc_r    <= smsp_pkg::BC_RST;
    end else if (lead_ev) begin
      if (!pha_r) samp_r <= din;                                    // [R16]
      else out_r <= shift_r[smsp_pkg::MSB];
    end else if (trail_ev) begin
      shift_r <= shift_nxt;                                         // [R03]
      bc_r    <= bc_r + 3'h1;                                       // [R20]
      if (!pha_r) out_r <= shift_r[smsp_pkg::MSB-1];
    end else if (!busy) begin
      out_r <= shift_r[smsp_pkg::MSB];
      if (slv_sel) bc_r <= smsp_pkg::BC_RST;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers; enables are active low
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sck_o       <= smsp_pkg::CFG_RST[smsp_pkg::CFG_POL];
      mosi_o      <= 1'b0;
      miso_o      <= 1'b0;
      sck_oe_n_o  <= 1'b1;
      mosi_oe_n_o <= 1'b1;
      miso_oe_n_o <= 1'b1;
    end else begin
      sck_o       <= sck_r;
      mosi_o      <= out_r;
      miso_o      <= out_r;
      sck_oe_n_o  <= !(en_r && master_select_bit_r);
      mosi_oe_n_o <= !(en_r && master_select_bit_r);
      miso_oe_n_o <= !slv_sel;                                      // [R04]
    end
  end

  // ----------------------------------------------------------------
  // Register read port; unmapped addresses read zero
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sfr_rdata_o <= smsp_pkg::DAT_RST;
    end else if (sfr_req_i.rd) begin
      if (hit(sfr_req_i.addr, smsp_pkg::ADDR_CFG)) begin
        sfr_rdata_o <= {pha_r, pol_r, bc_r, frs_r};                 // [R20]
      end else if (hit(sfr_req_i.addr, smsp_pkg::ADDR_CTL)) begin
        sfr_rdata_o <= {transfer_complete_flag_r, write_collision_flag_r, mode_fault_flag_r, ovr_r, mst_busy, !nss_s, master_select_bit_r, en_r};
      end else if (rd_dat) begin
        sfr_rdata_o <= rx_buf_r;
      end else if (hit(sfr_req_i.addr, smsp_pkg::ADDR_CKR)) begin
        sfr_rdata_o <= ckr_r;
      end else begin
        sfr_rdata_o <= smsp_pkg::DAT_RST;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [8:0] gap_r;
  logic       gap_ok_r;

  // Cycles since the previous divider tick, for the rate check
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !mst_busy) begin
      gap_r    <= smsp_pkg::GAP_RST;
      gap_ok_r <= 1'b0;
    end else if (tick) begin
      gap_r    <= smsp_pkg::GAP_RST;
      gap_ok_r <= 1'b1;
    end else begin
      gap_r    <= gap_r + 9'h001;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_rate;
    (tick && gap_ok_r && !wr_ckr) |-> (gap_r == {1'b0, ckr_r});
  endproperty
  a_rate: assert property (p_rate) else $error("tick spacing wrong"); // [R23]

  property p_msb;
    start |=> (out_r == $past(sfr_req_i.wdata[smsp_pkg::MSB])) ##1 (mosi_o == $past(out_r));
  endproperty
  a_msb: assert property (p_msb) else $error("first bit not msb"); // [R03]

  property p_hiz;
    !slv_sel |=> miso_oe_n_o;
  endproperty
  a_hiz: assert property (p_hiz) else $error("miso driven unselected"); // [R04]

  property p_start;
    start |=> mst_busy && (shift_r == $past(sfr_req_i.wdata)) && (bc_r == smsp_pkg::BC_RST);
  endproperty
  a_start: assert property (p_start) else $error("write did not start"); // [R06]

  property p_done;
    push |=> transfer_complete_flag_r ##1 irq_o;
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged"); // [R07]

  property p_len;
    mst_done |-> (bc_r == frs_r) ##1 (bc_r == $past(frs_r) + 3'h1);
  endproperty
  a_len: assert property (p_len) else $error("frame length wrong"); // [R22]

  property p_write_collision_flag;
    (write_collision_flag_ev && mst_busy && !mst_done && !mode_fault_flag_cond) |=> write_collision_flag_r && mst_busy;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision mishandled"); // [R10]

  property p_ovr;
    ovr_ev |=> ovr_r && $stable(rx_buf_r);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun mishandled"); // [R11]

  property p_mode_fault_flag;
    mode_fault_flag_cond |=> mode_fault_flag_r && !master_select_bit_r && !en_r && !mst_busy;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault mishandled"); // [R14]

  property p_sticky;
    (transfer_complete_flag_r && !wr_ctl) |=> transfer_complete_flag_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by hw"); // [R21]

  c_mst: cover property (mst_done);
  c_slv: cover property (slv_end);
  c_mode_fault_flag: cover property (mode_fault_flag_cond);
  c_ovr: cover property (ovr_ev);

endmodule : smsp_port

// File: sim/smsp_slave_model.sv
// Behavioural serial slave that answers the port while it runs as master.
// Assumes the bench drives its select and sets phase and polarity before selecting it.
`timescale 1ns/1ns
module smsp_slave_model (
  input  wire logic       sck_i,
  input  wire logic       sel_n_i,
  input  wire logic       mosi_i,
  input  wire logic       pha_i,
  input  wire logic       pol_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic [7:0]      rx_o
);
  logic [8:0] sh_r;
  // Phase one gets a dummy lead bit, so its first shift shows bit 7
  always @(negedge sel_n_i) begin
    sh_r = pha_i ? {~tx_i[7], tx_i} : {tx_i, 1'b0};
    miso_o = sh_r[8];
    rx_o = 8'h00;
  end
  // Released line shows the inverse, never the last bit
  always @(posedge sel_n_i) miso_o = ~miso_o;
  // Sample on one edge kind, shift on the other; MSB first both ways
  always @(sck_i) begin
    if (!sel_n_i && (sck_i ^ pol_i ^ pha_i)) begin
      rx_o = {rx_o[6:0], mosi_i};
    end else if (!sel_n_i) begin
      sh_r = {sh_r[7:0], 1'b0};
      miso_o = sh_r[8];
    end
  end
  initial miso_o = 1'b0;
endmodule : smsp_slave_model

// File: sim/tb.sv
// Testbench: register-port driver, read checks through a queue, master and slave frames.
// Assumes the port and the slave model are compiled before it.
`timescale 1ns/1ns
module tb;
  logic core_clk_i, srst_i, nss_n_i, sck_i, mosi_i, sel_n, rd_seen, pha, pol;
  logic irq, sck_o, mosi_o, miso_o, miso_oe_n, miso_m, sck_q;
  logic [7:0] rdata, st, rx, got, d, v, mk;
  logic [15:0] expq[$];
  int bad_count, samples_checked, edges, cyc;
  smsp_pkg::smsp_sfr_req_t req;
  smsp_port DUT (.core_clk_i(core_clk_i), .srst_i(srst_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .irq_o(irq), .nss_n_i(nss_n_i), .sck_i(sck_i), .sck_o(sck_o), .sck_oe_n_o(), .mosi_i(mosi_i),
    .mosi_o(mosi_o), .mosi_oe_n_o(), .miso_i(miso_m), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n));
  smsp_slave_model slv (.sck_i(sck_o), .sel_n_i(sel_n), .mosi_i(mosi_o), .pha_i(pha), .pol_i(pol),
    .tx_i(st), .miso_o(miso_m), .rx_o(rx));
  // ----------------------------------------------------------------
  // Clock, read monitor, edge counter and hang limit
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) rd_seen <= req.rd;
  // Negedge look avoids racing a back-to-back read's update
  always @(negedge core_clk_i) begin
    if (rd_seen && expq.size() > 0) begin
      mk = expq[0][15:8];
      check("rdata", rdata & mk, expq.pop_front() & mk);
    end
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (sck_o !== sck_q) edges++;
    sck_q = sck_o;
    if (cyc == 40000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic check(string nm, logic [7:0] s, logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge core_clk_i) req <= '{1'b1, 1'b0, a, v};
    @(posedge core_clk_i) req <= '0;
  endtask : wr
  // Mask marks which bits of the read are defined
  task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
    expq.push_back({m, e});
    @(posedge core_clk_i) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk_i) req <= '0;
  endtask : rd
  task automatic xfer(logic [7:0] v, int cnt, bit col = 0);
    edges = 0;
    wr(smsp_pkg::ADDR_DAT, v);
    if (col) wr(smsp_pkg::ADDR_DAT, ~v);
    for (int i = 0; i < 3000 && edges < cnt; i++) @(posedge core_clk_i);
    repeat (3) @(posedge core_clk_i);
  endtask : xfer
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    req = '0;
    srst_i = 1'b1;
    nss_n_i = 1'b1;
    sck_i = 1'b0;
    mosi_i = 1'b0;
    sel_n = 1'b1;
    st = 8'h00;
    void'($urandom(60994));
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(smsp_pkg::ADDR_CFG, 8'h07);
    rd(smsp_pkg::ADDR_CTL, 8'h00);
    rd(8'h9c, 8'h00);
    // Every frame size, random mode, rate and data
    for (int k = 0; k < 8; k++) begin
      {pha, pol} = 2'($urandom);
      st = 8'($urandom);
      wr(smsp_pkg::ADDR_CTL, 8'h00);
      wr(smsp_pkg::ADDR_CFG, {pha, pol, 3'h0, 3'(k)});
      // Half period of four cycles or more covers the slave-out synchroniser delay
      wr(smsp_pkg::ADDR_CKR, 8'($urandom_range(6, 3)));
      rd(smsp_pkg::ADDR_CTL, 8'h00);
      wr(smsp_pkg::ADDR_CTL, 8'h03);
      check("sck idle", {7'h0, sck_o}, {7'h0, pol});
      sel_n = 1'b0;
      v = 8'($urandom);
      xfer(v, 2 * k + 2);
      check("sck edges", 8'(edges), 8'(2 * k + 2));
      sel_n = 1'b1;
      check("slave rx", rx, v >> (7 - k));
      rd(smsp_pkg::ADDR_DAT, st >> (7 - k), 8'hff >> (7 - k));
      rd(smsp_pkg::ADDR_CTL, 8'h83);
      wr(smsp_pkg::ADDR_CTL, 8'h03);
    end
    // Unread buffer then a colliding write
    sel_n = 1'b0;
    xfer(8'h3c, 16);
    sel_n = 1'b1;
    wr(smsp_pkg::ADDR_CTL, 8'h03);
    st = ~st;
    sel_n = 1'b0;
    xfer(8'ha5, 16, 1);
    sel_n = 1'b1;
    check("slave rx", rx, 8'ha5);
    rd(smsp_pkg::ADDR_CTL, 8'hd3);
    rd(smsp_pkg::ADDR_DAT, ~st);
    wr(smsp_pkg::ADDR_CTL, 8'h03);
    // Select pulled low while master
    nss_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    rd(smsp_pkg::ADDR_CTL, 8'h24);
    nss_n_i <= 1'b1;
    wr(smsp_pkg::ADDR_CTL, 8'h00);
    // Slave frame, mode 0, half period 6 cycles
    wr(smsp_pkg::ADDR_CFG, 8'h07);
    wr(smsp_pkg::ADDR_CTL, 8'h01);
    d = 8'($urandom);
    st = 8'($urandom);
    wr(smsp_pkg::ADDR_DAT, d);
    check("miso oe", {7'h0, miso_oe_n}, 8'h01);
    nss_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    for (int i = 7; i >= 0; i--) begin
      mosi_i <= st[i];
      repeat (6) @(posedge core_clk_i);
      sck_i <= 1'b1;
      got[i] = miso_o;
      repeat (6) @(posedge core_clk_i);
      sck_i <= 1'b0;
    end
    repeat (6) @(posedge core_clk_i);
    nss_n_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    check("slave tx", got, d);
    check("irq", {7'h0, irq}, 8'h01);
    rd(smsp_pkg::ADDR_DAT, st);
    rd(smsp_pkg::ADDR_CTL, 8'h81);
    repeat (2) @(posedge core_clk_i);
    test_done();
  end
endmodule : tb
